// ---- lsr_pkg.sv ----
`default_nettype none
// ------------------------------------------------------------
// Shared constants of the light sensor readout block.
// ------------------------------------------------------------
package lsr_pkg;

    // ------------------------------------------------------------
    // Register map, indexed by address bits 2:0.
    // ------------------------------------------------------------
    localparam logic [2:0] REG_CMD     = 3'h0;
    localparam logic [2:0] REG_CTL     = 3'h1;
    localparam logic [2:0] REG_THR_HI  = 3'h2;
    localparam logic [2:0] REG_THR_LO  = 3'h3;
    localparam logic [2:0] REG_DATA_LO = 3'h4;
    localparam logic [2:0] REG_DATA_HI = 3'h5;
    localparam logic [2:0] REG_TMR_LO  = 3'h6;
    localparam logic [2:0] REG_TMR_HI  = 3'h7;

    // ------------------------------------------------------------
    // Address strobe bits and field positions.
    // ------------------------------------------------------------
    localparam int ADDR_SYNC_BIT   = 7;
    localparam int ADDR_CLRINT_BIT = 6;
    localparam int CMD_EN_BIT      = 7;
    localparam int CMD_PD_BIT      = 6;
    localparam int CMD_TIMING_BIT  = 5;
    localparam int CMD_DSEL_LSB    = 2;
    localparam int CMD_WIDTH_LSB   = 0;
    localparam int CTL_FLAG_BIT    = 5;
    localparam int CTL_GAIN_LSB    = 2;
    localparam int CTL_PERS_LSB    = 0;

    // ------------------------------------------------------------
    // Reset values and fixed codes.
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_RESET    = 8'h00;
    localparam logic [1:0] GAIN_RESET   = 2'h0;
    localparam logic [1:0] PERS_RESET   = 2'h0;
    localparam logic [7:0] THR_HI_RESET = 8'hff;
    localparam logic [7:0] THR_LO_RESET = 8'h00;
    localparam logic [6:0] SLAVE_ADDR   = 7'h44;
    localparam logic [1:0] DSEL_D1      = 2'h0;
    localparam logic [1:0] DSEL_D2      = 2'h1;
    localparam logic [1:0] DSEL_DIFF    = 2'h2;
    localparam logic [1:0] DSEL_NOP     = 2'h3;

    // ------------------------------------------------------------
    // Counts: conversion cycles, persistence, range constants.
    // ------------------------------------------------------------
    localparam logic [16:0] CYC_W0 = 17'h10000;
    localparam logic [16:0] CYC_W1 = 17'h01000;
    localparam logic [16:0] CYC_W2 = 17'h00100;
    localparam logic [16:0] CYC_W3 = 17'h00010;
    localparam logic [4:0]  PERS_M0 = 5'h01;
    localparam logic [4:0]  PERS_M1 = 5'h04;
    localparam logic [4:0]  PERS_M2 = 5'h08;
    localparam logic [4:0]  PERS_M3 = 5'h10;
    localparam logic [15:0] RANGE_K1 = 16'h03cd;
    localparam logic [15:0] RANGE_K2 = 16'h0f34;
    localparam logic [15:0] RANGE_K3 = 16'h3cd0;
    localparam logic [15:0] RANGE_K4 = 16'hf340;

    typedef enum logic [1:0] {PH_IDLE, PH_FIRST, PH_SECOND} lsr_phase_e;

endpackage
`default_nettype wire

// ---- lsr_accum.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Signed charge-balance pulse accumulator.
// ------------------------------------------------------------
module lsr_accum (
    input  wire logic               clk_i,
    input  wire logic               rstn_i,
    input  wire logic               clear_i,
    input  wire logic               inc_i,
    input  wire logic               dec_i,
    output logic signed [17:0]      acc_o
);

    logic signed [17:0] acc_ff;
    logic signed [17:0] nxt_acc;
    wire                at_top = (acc_ff == 18'sh1ffff);
    wire                at_bot = (acc_ff == -18'sh1ffff);

    // Saturation keeps a long bright integration from wrapping negative.
    assign nxt_acc = clear_i           ? 18'sh00000 :
                     (inc_i && !at_top) ? acc_ff + 18'sh00001 :
                     (dec_i && !at_bot) ? acc_ff - 18'sh00001 : acc_ff;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc_ff <= 18'sh00000;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    assign acc_o = acc_ff;

endmodule // lsr_accum
`default_nettype wire

// ---- lsr_persist.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Threshold window check with consecutive persistence count.
// ------------------------------------------------------------
module lsr_persist (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        clear_i,
    input  wire logic        sample_i,
    input  wire logic [15:0] value_i,
    input  wire logic [15:0] hi_i,
    input  wire logic [15:0] lo_i,
    input  wire logic [4:0]  need_i,
    output logic             trig_o
);

    logic [4:0] run_ff;
    logic [4:0] nxt_run;
    wire        outside = (value_i > hi_i) || (value_i < lo_i);
    wire [4:0]  run_inc = (run_ff == 5'h1f) ? run_ff : run_ff + 5'h01;

    assign nxt_run = clear_i                 ? 5'h00 :
                     (sample_i && !outside) ? 5'h00 :
                     (sample_i && outside)  ? run_inc : run_ff;

    assign trig_o = sample_i && outside && !clear_i && (run_inc >= need_i);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_ff <= 5'h00;
        end else begin
            run_ff <= nxt_run;
        end
    end

endmodule // lsr_persist
`default_nettype wire

// ---- lsr_core.sv ----
`timescale 1ns/1ns
`default_nettype none
module lsr_core (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [6:0]  slave_addr_i,
    output logic             addr_match_o,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic [7:0]       reg_rdata_o,
    input  wire logic        osc_tick_i,
    input  wire logic        adc_pulse_i,
    output logic             adc_reset_o,
    output logic             power_down_o,
    output logic             diode_sel_o,
    output logic             osc_fast_o,
    output logic [1:0]       gain_o,
    output logic [15:0]      range_const_o,
    output logic             int_n_o
);

    // ------------------------------------------------------------
    // Decoding helpers.
    // ------------------------------------------------------------
    function automatic logic plain_hit(input logic [7:0] addr, input logic [2:0] idx);
        plain_hit = (addr[7:3] == 5'h00) && (addr[2:0] == idx);
    endfunction

    function automatic logic [16:0] width_cycles(input logic [1:0] w);
        unique case (w)
            2'h0: width_cycles = lsr_pkg::CYC_W0;
            2'h1: width_cycles = lsr_pkg::CYC_W1;
            2'h2: width_cycles = lsr_pkg::CYC_W2;
            2'h3: width_cycles = lsr_pkg::CYC_W3;
        endcase
    endfunction

    function automatic logic [4:0] persist_need(input logic [1:0] p);
        unique case (p)
            2'h0: persist_need = lsr_pkg::PERS_M0;
            2'h1: persist_need = lsr_pkg::PERS_M1;
            2'h2: persist_need = lsr_pkg::PERS_M2;
            2'h3: persist_need = lsr_pkg::PERS_M3;
        endcase
    endfunction

    function automatic logic [15:0] range_const(input logic [1:0] g);
        unique case (g)
            2'h0: range_const = lsr_pkg::RANGE_K1;
            2'h1: range_const = lsr_pkg::RANGE_K2;
            2'h2: range_const = lsr_pkg::RANGE_K3;
            2'h3: range_const = lsr_pkg::RANGE_K4;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------
    logic [7:0]         cmd_ff;
    logic [1:0]         gain_ff;
    logic [1:0]         pers_ff;
    logic               flag_ff;
    logic [7:0]         thr_hi_ff;
    logic [7:0]         thr_lo_ff;
    logic [15:0]        data_ff;
    logic [15:0]        tmr_cap_ff;
    logic [16:0]        tick_cnt_ff;
    logic [15:0]        tmr_cnt_ff;
    logic               diode_sel_ff;
    logic [7:0]         rdata_ff;
    lsr_pkg::lsr_phase_e phase_ff;
    lsr_pkg::lsr_phase_e nxt_phase;

    // ------------------------------------------------------------
    // Address match and write decode.
    // ------------------------------------------------------------
    // fixed slave address
    assign addr_match_o = (slave_addr_i == lsr_pkg::SLAVE_ADDR);

    wire wr_sync  = reg_wr_i && reg_addr_i[lsr_pkg::ADDR_SYNC_BIT];
    wire wr_clr   = reg_wr_i && reg_addr_i[lsr_pkg::ADDR_CLRINT_BIT];
    wire wr_cmd   = reg_wr_i && plain_hit(reg_addr_i, lsr_pkg::REG_CMD);
    wire wr_ctl   = reg_wr_i && plain_hit(reg_addr_i, lsr_pkg::REG_CTL);
    wire wr_thr_h = reg_wr_i && plain_hit(reg_addr_i, lsr_pkg::REG_THR_HI);
    wire wr_thr_l = reg_wr_i && plain_hit(reg_addr_i, lsr_pkg::REG_THR_LO);

    // ------------------------------------------------------------
    // Command fields.
    // ------------------------------------------------------------
    wire       cmd_en   = cmd_ff[lsr_pkg::CMD_EN_BIT];
    wire       converter_power_down = cmd_ff[lsr_pkg::CMD_PD_BIT];
    wire       ext_mode = cmd_ff[lsr_pkg::CMD_TIMING_BIT];
    wire [1:0] dsel     = cmd_ff[lsr_pkg::CMD_DSEL_LSB +: 2];
    wire [1:0] width    = cmd_ff[lsr_pkg::CMD_WIDTH_LSB +: 2];

    wire adc_run = cmd_en && !converter_power_down && (dsel != lsr_pkg::DSEL_NOP);

    wire [16:0] conv_len = width_cycles(width);

    // ------------------------------------------------------------
    // Integration timing.
    // ------------------------------------------------------------
    // internal cycle count
    wire int_end = osc_tick_i && (tick_cnt_ff == conv_len - 17'h00001);

    wire phase_end = adc_run && (phase_ff != lsr_pkg::PH_IDLE)
                     && (ext_mode ? wr_sync : int_end);

    wire last_phase = (dsel != lsr_pkg::DSEL_DIFF) || (phase_ff == lsr_pkg::PH_SECOND);
    wire result_end = phase_end && last_phase;

    // The difference mode runs diode one, then diode two, as two phases.
    always_comb begin
        nxt_phase = phase_ff;
        if (!adc_run) begin
            nxt_phase = lsr_pkg::PH_IDLE;
        end else begin
            unique case (phase_ff)
                lsr_pkg::PH_IDLE: begin
                    nxt_phase = lsr_pkg::PH_FIRST;
                end
                lsr_pkg::PH_FIRST: begin
                    if (phase_end && !last_phase) begin
                        nxt_phase = lsr_pkg::PH_SECOND;
                    end
                end
                lsr_pkg::PH_SECOND: begin
                    if (phase_end) begin
                        nxt_phase = lsr_pkg::PH_FIRST;
                    end
                end
            endcase
        end
    end

    wire [16:0] nxt_tick = (!adc_run || phase_end) ? 17'h00000 :
                           osc_tick_i ? tick_cnt_ff + 17'h00001 : tick_cnt_ff;

    wire [15:0] nxt_tmr  = (!adc_run || result_end) ? 16'h0000 :
                           osc_tick_i ? tmr_cnt_ff + 16'h0001 : tmr_cnt_ff;

    // ------------------------------------------------------------
    // Conversion result.
    // ------------------------------------------------------------
    wire               in_second = (phase_ff == lsr_pkg::PH_SECOND);
    wire               counting  = adc_run && (phase_ff != lsr_pkg::PH_IDLE);
    logic signed [17:0] acc;

    lsr_accum u_accum (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .clear_i (!adc_run || result_end),
        .inc_i   (counting && adc_pulse_i && !in_second),
        .dec_i   (counting && adc_pulse_i && in_second),
        .acc_o   (acc)
    );

    // Clipping keeps the code inside n bits, or n-1 signed bits plus sign.
    wire signed [17:0] full_max = $signed({1'b0, conv_len}) - 18'sh00001;
    wire signed [17:0] half_max = $signed({2'b00, conv_len[16:1]}) - 18'sh00001;
    wire signed [17:0] half_min = -$signed({2'b00, conv_len[16:1]});
    wire signed [17:0] uns_res  = (acc < 18'sh00000) ? 18'sh00000 :
                                  (acc > full_max) ? full_max : acc;
    wire signed [17:0] sgn_res  = (acc > half_max) ? half_max :
                                  (acc < half_min) ? half_min : acc;
    wire [17:0]        res_raw  = (dsel == lsr_pkg::DSEL_DIFF) ? sgn_res : uns_res;
    wire [15:0]        result   = res_raw[15:0];

    // ------------------------------------------------------------
    // Threshold and interrupt flag.
    // ------------------------------------------------------------
    // high expanded threshold
    wire [15:0] thr_hi_full = {thr_hi_ff, 8'h00};
    wire [15:0] thr_lo_full = {thr_lo_ff, 8'h00};
    wire        trig;

    lsr_persist u_persist (
        .clk_i    (clk_i),
        .rstn_i   (rstn_i),
        .clear_i  (!adc_run),
        .sample_i (result_end),
        .value_i  (result),
        .hi_i     (thr_hi_full),
        .lo_i     (thr_lo_full),
        .need_i   (persist_need(pers_ff)),
        .trig_o   (trig)
    );

    wire flag_clr = wr_clr || (wr_ctl && !reg_wdata_i[lsr_pkg::CTL_FLAG_BIT]);
    wire nxt_flag = trig || (flag_ff && !flag_clr);

    // ------------------------------------------------------------
    // Read path.
    // ------------------------------------------------------------
    wire [7:0] ctl_view = {2'b00, flag_ff, 1'b0, gain_ff, pers_ff};
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr_i[7:3] == 5'h00) begin
            unique case (reg_addr_i[2:0])
                lsr_pkg::REG_CMD:     rd_mux = {cmd_ff[7:5], 1'b0, cmd_ff[3:0]};
                lsr_pkg::REG_CTL:     rd_mux = ctl_view;
                lsr_pkg::REG_THR_HI:  rd_mux = thr_hi_ff;
                lsr_pkg::REG_THR_LO:  rd_mux = thr_lo_ff;
                lsr_pkg::REG_DATA_LO: rd_mux = data_ff[7:0];
                lsr_pkg::REG_DATA_HI: rd_mux = data_ff[15:8];
                lsr_pkg::REG_TMR_LO:  rd_mux = tmr_cap_ff[7:0];
                lsr_pkg::REG_TMR_HI:  rd_mux = tmr_cap_ff[15:8];
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control register storage.
    // ------------------------------------------------------------
    // Reserved bits are stored as zero so factory modes never engage.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_ff    <= lsr_pkg::CMD_RESET;
            gain_ff   <= lsr_pkg::GAIN_RESET;
            pers_ff   <= lsr_pkg::PERS_RESET;
            thr_hi_ff <= lsr_pkg::THR_HI_RESET;
            thr_lo_ff <= lsr_pkg::THR_LO_RESET;
            flag_ff   <= 1'b0;
        end else begin
            if (wr_cmd) begin
                cmd_ff <= {reg_wdata_i[7:5], 1'b0, reg_wdata_i[3:0]};
            end
            if (wr_ctl) begin
                gain_ff <= reg_wdata_i[lsr_pkg::CTL_GAIN_LSB +: 2];
                pers_ff <= reg_wdata_i[lsr_pkg::CTL_PERS_LSB +: 2];
            end
            if (wr_thr_h) begin
                thr_hi_ff <= reg_wdata_i;
            end
            if (wr_thr_l) begin
                thr_lo_ff <= reg_wdata_i;
            end
            flag_ff <= nxt_flag;
        end
    end

    // ------------------------------------------------------------
    // Conversion state and result latches.
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_ff    <= lsr_pkg::PH_IDLE;
            tick_cnt_ff <= 17'h00000;
            tmr_cnt_ff  <= 16'h0000;
        end else begin
            phase_ff    <= nxt_phase;
            tick_cnt_ff <= nxt_tick;
            tmr_cnt_ff  <= nxt_tmr;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_ff    <= 16'h0000;
            tmr_cap_ff <= 16'h0000;
        end else if (result_end) begin
            data_ff    <= result;
            tmr_cap_ff <= tmr_cnt_ff;
        end
    end

    // ------------------------------------------------------------
    // Output flops.
    // ------------------------------------------------------------
    wire nxt_dsel = (dsel == lsr_pkg::DSEL_D2)
                    || ((dsel == lsr_pkg::DSEL_DIFF) && (nxt_phase == lsr_pkg::PH_SECOND));

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            diode_sel_ff <= 1'b0;
            rdata_ff     <= 8'h00;
        end else begin
            diode_sel_ff <= nxt_dsel;
            if (reg_rd_i) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    assign reg_rdata_o   = rdata_ff;
    assign adc_reset_o   = !cmd_en;
    assign power_down_o  = converter_power_down;
    assign diode_sel_o   = diode_sel_ff;
    // The faster oscillator serves the two upper ranges.
    assign osc_fast_o    = gain_ff[1];
    assign gain_o        = gain_ff;
    assign range_const_o = range_const(gain_ff);
    assign int_n_o       = !flag_ff;

endmodule // lsr_core
`default_nettype wire

// ---- lsr_props.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Port checker of the readout core.
// ----------------------------------------
module lsr_props (
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic [6:0]  slave_addr_i,
    input wire logic        addr_match_o,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        osc_tick_i,
    input wire logic        adc_pulse_i,
    input wire logic        adc_reset_o,
    input wire logic        power_down_o,
    input wire logic        diode_sel_o,
    input wire logic        osc_fast_o,
    input wire logic [1:0]  gain_o,
    input wire logic [15:0] range_const_o,
    input wire logic        int_n_o
);
    logic latch_ev;
    logic cmd_wr;
    logic ctl_wr;
    assign latch_ev = osc_tick_i || (reg_wr_i && reg_addr_i[7]);
    assign cmd_wr   = reg_wr_i && (reg_addr_i == 8'h00);
    assign ctl_wr   = reg_wr_i && (reg_addr_i == 8'h01);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    AST_ADDR_MATCH: assert property (addr_match_o == (slave_addr_i == 7'h44))
        else $error("slave address match wrong");
    AST_EN_RESET: assert property (cmd_wr |=> adc_reset_o == !$past(reg_wdata_i[7]))
        else $error("core reset does not follow enable bit");
    AST_PWR_DOWN: assert property (cmd_wr |=> power_down_o == $past(reg_wdata_i[6]))
        else $error("power down does not follow its bit");
    AST_GAIN_WR: assert property (ctl_wr |=> gain_o == $past(reg_wdata_i[3:2])
        && osc_fast_o == $past(reg_wdata_i[3])) else $error("gain write not applied");
    // The four range constants are 973 times a power of four.
    AST_RANGE: assert property (range_const_o == (16'h03cd << {gain_o, 1'b0}))
        else $error("range constant wrong");
    AST_INT_CLR: assert property ($rose(int_n_o) |-> $past(reg_wr_i)
        && ($past(reg_addr_i[6]) || $past(reg_addr_i) == 8'h01)) else $error("stray clear");
    AST_INT_SET: assert property ($fell(int_n_o) |-> $past(latch_ev) || $past(latch_ev, 2))
        else $error("interrupt raised without a result");
    AST_RD_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
    AST_UNMAPPED: assert property (reg_rd_i && reg_addr_i[5:3] != 3'h0 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");

    COV_INT: cover property ($fell(int_n_o));
    COV_SYNC: cover property (reg_wr_i && reg_addr_i[7]);
    COV_CLR: cover property (reg_wr_i && reg_addr_i[6]);
endmodule // lsr_props
`default_nettype wire

// ---- lsr_frontend_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Oscillator and diode front end model.
// ----------------------------------------
module lsr_frontend_model (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic run_i,
    input  wire logic fast_i,
    output logic      osc_tick_o,
    output logic      adc_pulse_o
);
    logic [2:0] div_ff;
    // oscillator tick source.
    // Ticks stop one cycle after the core enters reset or power down: the tick flop still samples the old run_i on that edge.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_ff     <= 3'h0;
            osc_tick_o <= 1'b0;
        end else begin
            div_ff     <= run_i ? div_ff + 3'h1 : 3'h0;
            osc_tick_o <= run_i && (fast_i ? div_ff[1:0] == 2'h3 : div_ff == 3'h7);
        end
    end
    // Constant bright light: one charge pulse on every tick.
    assign adc_pulse_o = osc_tick_o;
endmodule // lsr_frontend_model
`default_nettype wire

// ---- lsr_core_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
    $display("Error at %0t got %h expected %h", $time, a, e); end end
module lsr_core_bench;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [6:0]  slave_addr_i = 7'h44;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic [7:0]  reg_rdata_o;
    logic        addr_match_o;
    logic        osc_tick_i;
    logic        adc_pulse_i;
    logic        adc_reset_o;
    logic        power_down_o;
    logic        diode_sel_o;
    logic        osc_fast_o;
    logic [1:0]  gain_o;
    logic [15:0] range_const_o;
    logic        int_n_o;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [7:0]  rst_tab [8] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [15:0] rng_tab [4] = '{16'd973, 16'd3892, 16'd15568, 16'd62272};

    lsr_core lsr_core_i (.clk_i(clk_i), .rstn_i(rstn_i), .slave_addr_i(slave_addr_i),
        .addr_match_o(addr_match_o), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .osc_tick_i(osc_tick_i), .adc_pulse_i(adc_pulse_i), .adc_reset_o(adc_reset_o),
        .power_down_o(power_down_o), .diode_sel_o(diode_sel_o), .osc_fast_o(osc_fast_o),
        .gain_o(gain_o), .range_const_o(range_const_o), .int_n_o(int_n_o));
    lsr_frontend_model lsr_frontend_model_i (.clk_i(clk_i), .rstn_i(rstn_i),
        .run_i(!adc_reset_o && !power_down_o), .fast_i(osc_fast_o),
        .osc_tick_o(osc_tick_i), .adc_pulse_o(adc_pulse_i));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The run is a few thousand cycles; a hang stops here.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        `CHK(reg_rdata_o, e)
        @(negedge clk_i);
    endtask

    task automatic ticks(input int n);
        for (int k = 0; k < n;) begin
            @(posedge clk_i);
            if (osc_tick_i === 1'b1) k++;
        end
        @(negedge clk_i);
    endtask

    initial begin
        repeat (6) @(negedge clk_i);
        rstn_i = 1'b1;
        `CHK(adc_reset_o, 1'b1)
        `CHK(int_n_o, 1'b1)
        for (int i = 0; i < 8; i++) rc(i[7:0], rst_tab[i]);
        rc(8'h08, 8'h00);
        slave_addr_i = 7'h45;
        #1 `CHK(addr_match_o, 1'b0)
        @(negedge clk_i);
        slave_addr_i = 7'h44;
        #1 `CHK(addr_match_o, 1'b1)
        @(negedge clk_i);
        for (int g = 0; g < 4; g++) begin
            wr(8'h01, 8'hf0 | (g[7:0] << 2));
            rc(8'h01, g[7:0] << 2);
            `CHK(range_const_o, rng_tab[g])
        end
        wr(8'h01, 8'h0c);
        wr(8'h00, 8'h83);
        rc(8'h00, 8'h83);
        ticks(64);
        `CHK(int_n_o, 1'b1)
        rc(8'h04, 8'h0f);
        rc(8'h05, 8'h00);
        rc(8'h06, 8'h0f);
        rc(8'h07, 8'h00);
        wr(8'h03, 8'h01);
        ticks(20);
        `CHK(int_n_o, 1'b0)
        rc(8'h01, 8'h2c);
        wr(8'h00, 8'hc3);
        `CHK(power_down_o, 1'b1)
        wr(8'h01, 8'h0c);
        `CHK(int_n_o, 1'b1)
        wr(8'h00, 8'h83);
        ticks(20);
        `CHK(int_n_o, 1'b0)
        wr(8'h00, 8'h03);
        `CHK(adc_reset_o, 1'b1)
        wr(8'h40, 8'h00);
        `CHK(int_n_o, 1'b1)
        rc(8'h00, 8'h03);
        wr(8'h01, 8'h0f);
        wr(8'h00, 8'h83);
        ticks(240);
        `CHK(int_n_o, 1'b1)
        ticks(40);
        `CHK(int_n_o, 1'b0)
        wr(8'h00, 8'h03);
        wr(8'h40, 8'h00);
        wr(8'h01, 8'h0c);
        wr(8'h00, 8'ha3);
        ticks(1);
        wr(8'h80, 8'h00);
        ticks(9);
        wr(8'h80, 8'h00);
        rc(8'h04, 8'h09);
        rc(8'h06, 8'h09);
        rc(8'h07, 8'h00);
        // Difference mode: one pulse on diode one, nine on diode two.
        wr(8'h00, 8'h03);
        wr(8'h00, 8'hab);
        `CHK(diode_sel_o, 1'b0)
        ticks(1);
        wr(8'h80, 8'h00);
        `CHK(diode_sel_o, 1'b1)
        ticks(9);
        wr(8'h80, 8'h00);
        `CHK(diode_sel_o, 1'b0)
        rc(8'h04, 8'hf8);
        rc(8'h05, 8'hff);
        wr(8'h00, 8'h03);
        wr(8'h00, 8'h86);
        `CHK(diode_sel_o, 1'b1)
        ticks(256);
        rc(8'h04, 8'hff);
        rc(8'h05, 8'h00);
        rc(8'h06, 8'hff);
        end_of_test();
    end
endmodule // lsr_core_bench

bind lsr_core lsr_props lsr_props_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .slave_addr_i(slave_addr_i), .addr_match_o(addr_match_o), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .osc_tick_i(osc_tick_i), .adc_pulse_i(adc_pulse_i),
    .adc_reset_o(adc_reset_o), .power_down_o(power_down_o), .diode_sel_o(diode_sel_o),
    .osc_fast_o(osc_fast_o), .gain_o(gain_o), .range_const_o(range_const_o),
    .int_n_o(int_n_o));
`default_nettype wire
